// ==== inc/npic_pkg.sv ====
// Constants, types and helpers for the nested priority interrupt controller.
// Assumes a 200 MHz CPU clock and an APB master with 32-bit data.
package npic_pkg;

    localparam int          NVEC          = 14;
    localparam int          NEXT          = 4;
    localparam int          PINS_PER_LINE = 4;
    localparam int          NPER          = NVEC - NEXT;
    localparam int          IDX_W         = 4;

    // Priority pair encodings, high bit first
    localparam logic [1:0]  LVL0          = 2'h2;
    localparam logic [1:0]  LVL1          = 2'h1;
    localparam logic [1:0]  LVL2          = 2'h0;
    localparam logic [1:0]  LVL3          = 2'h3;

    // Positions of the priority pair in the condition code byte
    localparam int          CC_HI_BIT     = 5;
    localparam int          CC_LO_BIT     = 3;

    // Vector addresses: reset, trap, then vector 0 downward
    localparam logic [15:0] VEC_RESET     = 16'hFFFE;
    localparam logic [15:0] VEC_TRAP      = 16'hFFFC;
    localparam logic [15:0] VEC_BASE      = 16'hFFFA;
    localparam logic [3:0]  IDX_TRAP      = 4'hE;
    localparam logic [3:0]  IDX_RESET     = 4'hF;

    // APB register map, byte addresses
    localparam int          ADDR_W        = 8;
    localparam logic [7:0]  ADDR_PRIO0    = 8'h00;
    localparam logic [7:0]  ADDR_PRIO1    = 8'h04;
    localparam logic [7:0]  ADDR_PRIO2    = 8'h08;
    localparam logic [7:0]  ADDR_PRIO3    = 8'h0C;
    localparam logic [7:0]  ADDR_PEND     = 8'h10;
    localparam logic [7:0]  ADDR_HALTCAP  = 8'h14;
    localparam logic [7:0]  REG_STRIDE    = 8'h04;

    // Reset values
    localparam logic [27:0] PRIO_RST      = 28'hFFFFFFF;
    localparam logic [3:0]  PRIO3_ONES    = 4'hF;
    localparam logic [13:0] HALTCAP_RST   = 14'h000F;

    typedef enum logic [1:0] {
        NPIC_RUN  = 2'h0,
        NPIC_WAIT = 2'h1,
        NPIC_HALT = 2'h3
    } npic_sleep_e;

    // Maps a priority pair to an ordinal: 0 lowest, 3 highest
    function automatic logic [1:0] npic_rank(input logic [1:0] lvl);
        logic [1:0] r;
        case (lvl)
            LVL0:    r = 2'h0;
            LVL1:    r = 2'h1;
            LVL2:    r = 2'h2;
            default: r = 2'h3;
        endcase
        return r;
    endfunction : npic_rank

endpackage : npic_pkg

// ==== rtl/npic_ctrl.sv ====
// Nested priority interrupt controller beside an 8-bit CPU core.
// Assumes inputs synchronous to clk; the core fetches on irq_take and stacks only when irq_stack is also set.
// Core samples irq_index, irq_prio and irq_vector together with irq_take.
`timescale 1ns/1ps

module npic_ctrl (
    input  wire logic                                  clk,
    input  wire logic                                  resetn,
    // APB slave
    input  wire logic [npic_pkg::ADDR_W-1:0]           paddr,
    input  wire logic                                  psel,
    input  wire logic                                  penable,
    input  wire logic                                  pwrite,
    input  wire logic [31:0]                           pwdata,
    output logic      [31:0]                           prdata,
    output logic                                       pready,
    output logic                                       pslverr,
    // External pins and their enables
    input  wire logic [npic_pkg::NEXT*npic_pkg::PINS_PER_LINE-1:0] ext_pin,
    input  wire logic [npic_pkg::NEXT*npic_pkg::PINS_PER_LINE-1:0] ext_pin_en,
    // Peripheral sources
    input  wire logic [npic_pkg::NPER-1:0]             periph_flag,
    input  wire logic [npic_pkg::NPER-1:0]             periph_en,
    input  wire logic [npic_pkg::NPER-1:0]             periph_clear,
    // CPU core sequencer
    input  wire logic                                  instr_boundary,
    input  wire logic                                  trap_op,
    input  wire logic                                  unmask_all_op,
    input  wire logic                                  mask_all_op,
    input  wire logic                                  halt_op,
    input  wire logic                                  sleep_until_event_op,
    input  wire logic                                  service_return_op,
    input  wire logic                                  cc_pop,
    input  wire logic [7:0]                            cc_restore,
    output logic                                       prio_level_hi,
    output logic                                       prio_level_lo,
    output logic                                       sleep_wait,
    output logic                                       sleep_halt,
    output logic                                       irq_take,
    output logic                                       irq_stack,
    output logic      [npic_pkg::IDX_W-1:0]            irq_index,
    output logic      [1:0]                            irq_prio,
    output logic      [15:0]                           irq_vector
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    logic [2*npic_pkg::NVEC-1:0] prio_q;
    logic [npic_pkg::NVEC-1:0]   haltcap_q;
    logic [npic_pkg::NVEC-1:0]   pend_q;
    logic [npic_pkg::NEXT-1:0]   line_q;
    logic [1:0]                  cc_q;
    npic_pkg::npic_sleep_e       sleep_q;
    logic                        reset_pend_q;
    logic                        trap_pend_q;
    logic                        take_q;
    logic                        stack_q;
    logic [npic_pkg::IDX_W-1:0]  index_q;
    logic [1:0]                  iprio_q;
    logic [15:0]                 vector_q;

    ////////////////////////////////////////////////////////////////////////////
    // APB decode

    wire         apb_acc    = psel & penable;
    wire         apb_wr     = apb_acc & pwrite;
    wire         hit_prio   = (paddr == npic_pkg::ADDR_PRIO0) | (paddr == npic_pkg::ADDR_PRIO1)
                            | (paddr == npic_pkg::ADDR_PRIO2) | (paddr == npic_pkg::ADDR_PRIO3);
    wire         hit_pend   = (paddr == npic_pkg::ADDR_PEND);
    wire         hit_hcap   = (paddr == npic_pkg::ADDR_HALTCAP);
    wire         hit_any    = hit_prio | hit_pend | hit_hcap;
    wire         wr_hcap    = apb_wr & hit_hcap;
    wire [31:0]  prio_flat  = {npic_pkg::PRIO3_ONES, prio_q};
    wire [1:0]   prio_sel   = paddr[3:2];
    wire [7:0]   prio_byte  = prio_flat[8*prio_sel +: 8];

    assign pready  = 1'b1;
    assign pslverr = apb_acc & ~hit_any;
    wire [31:0]  rd_prio    = {24'h000000, prio_byte};
    wire [31:0]  rd_pend    = {18'h00000, pend_q};
    wire [31:0]  rd_hcap    = {18'h00000, haltcap_q};

    assign prdata  = hit_prio ? rd_prio
                   : hit_pend ? rd_pend
                   : hit_hcap ? rd_hcap
                   : 32'h00000000;

    ////////////////////////////////////////////////////////////////////////////
    // Service sequencing and arbitration

    logic [1:0]                 rank_v [npic_pkg::NVEC];
    logic [npic_pkg::NVEC-1:0]  elig;
    logic [npic_pkg::NVEC-1:0]  vec_en;
    logic [npic_pkg::NVEC-1:0]  served;
    logic                       win_valid;
    logic [npic_pkg::IDX_W-1:0] win_idx;
    logic [1:0]                 best_rank;

    wire         in_halt   = (sleep_q == npic_pkg::NPIC_HALT);
    wire         asleep    = (sleep_q != npic_pkg::NPIC_RUN);
    wire [1:0]   cur_rank  = npic_pkg::npic_rank(cc_q);
    wire         take_ok   = instr_boundary | asleep;
    wire         take_rst  = reset_pend_q;
    wire         take_trp  = trap_pend_q & take_ok & ~take_rst;
    wire         take_msk  = win_valid & take_ok & ~take_rst & ~trap_pend_q;
    wire         take_any  = take_rst | take_trp | take_msk;
    wire [1:0]   win_prio  = prio_q[2*win_idx +: 2];
    wire [15:0]  win_vec   = npic_pkg::VEC_BASE - {11'h000, win_idx, 1'b0};

    // Software rank first, lower index breaks ties
    always_comb begin
        win_valid = 1'b0;
        win_idx   = '0;
        best_rank = 2'h0;
        for (int v = npic_pkg::NVEC - 1; v >= 0; v--) begin
            if (elig[v] && (!win_valid || rank_v[v] >= best_rank)) begin
                win_valid = 1'b1;
                win_idx   = v[npic_pkg::IDX_W-1:0];
                best_rank = rank_v[v];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-vector logic

    for (genvar v = 0; v < npic_pkg::NVEC; v++) begin : g_vec
        localparam logic [7:0] REG_ADDR = 8'(npic_pkg::ADDR_PRIO0
                                            + npic_pkg::REG_STRIDE * (v / 4));
        localparam int         POS      = 2 * (v % 4);
        wire       wr_pair  = apb_wr & (paddr == REG_ADDR);
        wire [1:0] wr_val   = pwdata[POS +: 2];
        wire       set_req;
        wire       clr_req;
        // External lines always wake from halt
        wire       hcap_val = (v < npic_pkg::NEXT) ? 1'b1 : pwdata[v];

        assign rank_v[v] = npic_pkg::npic_rank(prio_q[2*v +: 2]);
        assign served[v] = take_msk & (win_idx == v[npic_pkg::IDX_W-1:0]);
        // Enabled and strictly above current level
        // In halt only capable sources compete
        assign elig[v]   = pend_q[v] & vec_en[v] & (rank_v[v] > cur_rank)
                         & (~in_halt | haltcap_q[v]);

        if (v < npic_pkg::NEXT) begin : g_ext
            wire [npic_pkg::PINS_PER_LINE-1:0] pins =
                ext_pin[v*npic_pkg::PINS_PER_LINE +: npic_pkg::PINS_PER_LINE]
                & ext_pin_en[v*npic_pkg::PINS_PER_LINE +: npic_pkg::PINS_PER_LINE];
            wire line = |pins;
            assign vec_en[v] = |ext_pin_en[v*npic_pkg::PINS_PER_LINE +: npic_pkg::PINS_PER_LINE];
            assign set_req   = line & ~line_q[v];
            assign clr_req   = served[v];
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    line_q[v] <= 1'b0;
                end else begin
                    line_q[v] <= line;
                end
            end
        end else begin : g_per
            localparam int P = v - npic_pkg::NEXT;
            assign vec_en[v] = periph_en[P];
            assign set_req   = periph_flag[P] & periph_en[P];
            assign clr_req   = periph_clear[P];
        end

        // External lines latched until served, peripherals until periph_clear; set wins
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                pend_q[v] <= 1'b0;
            end else if (set_req) begin
                pend_q[v] <= 1'b1;
            end else if (clr_req) begin
                pend_q[v] <= 1'b0;
            end
        end

        // Level 0 write keeps old pair
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                prio_q[2*v +: 2] <= npic_pkg::PRIO_RST[2*v +: 2];
            end else if (wr_pair && wr_val != npic_pkg::LVL0) begin
                prio_q[2*v +: 2] <= wr_val;
            end
        end

        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                haltcap_q[v] <= npic_pkg::HALTCAP_RST[v];
            end else if (wr_hcap) begin
                haltcap_q[v] <= hcap_val;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Current priority pair

    logic [1:0] cc_d;
    // High bit 5, low bit 3
    wire  [1:0] ret_pair = {cc_restore[npic_pkg::CC_HI_BIT], cc_restore[npic_pkg::CC_LO_BIT]};

    always_comb begin
        cc_d = cc_q;
        if (take_rst || take_trp) begin
            cc_d = npic_pkg::LVL3;
        end else if (take_msk) begin
            cc_d = win_prio;
        end else if (cc_pop || service_return_op) begin
            // Restore stacked pair from CC bits 5,3
            cc_d = ret_pair;
        end else if (mask_all_op) begin
            cc_d = npic_pkg::LVL3;
        end else if (unmask_all_op || halt_op || sleep_until_event_op) begin
            // Unmask, halt and wait load level 0
            cc_d = npic_pkg::LVL0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cc_q <= npic_pkg::LVL3;
        end else begin
            cc_q <= cc_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Non-maskable latches: reset and trap

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reset_pend_q <= 1'b1;
        end else begin
            reset_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            trap_pend_q <= 1'b0;
        end else if (trap_op) begin
            trap_pend_q <= 1'b1;
        end else if (take_trp) begin
            trap_pend_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Low-power state

    npic_pkg::npic_sleep_e sleep_d;

    always_comb begin
        sleep_d = sleep_q;
        case (sleep_q)
            npic_pkg::NPIC_RUN: begin
                if (halt_op) begin
                    sleep_d = npic_pkg::NPIC_HALT;
                end else if (sleep_until_event_op) begin
                    sleep_d = npic_pkg::NPIC_WAIT;
                end
            end
            npic_pkg::NPIC_WAIT: begin
                if (take_any) begin
                    sleep_d = npic_pkg::NPIC_RUN;
                end
            end
            npic_pkg::NPIC_HALT: begin
                if (take_any) begin
                    sleep_d = npic_pkg::NPIC_RUN;
                end
            end
            default: begin
                sleep_d = npic_pkg::NPIC_RUN;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sleep_q <= npic_pkg::NPIC_RUN;
        end else begin
            sleep_q <= sleep_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Service request to the core

    wire [15:0]                 vec_d = take_rst ? npic_pkg::VEC_RESET
                                      : take_trp ? npic_pkg::VEC_TRAP : win_vec;
    wire [npic_pkg::IDX_W-1:0]  idx_d = take_rst ? npic_pkg::IDX_RESET
                                      : take_trp ? npic_pkg::IDX_TRAP : win_idx;

    wire                        stack_d = take_any & ~take_rst;

    // Nesting follows from the level compare
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            take_q  <= 1'b0;
            stack_q <= 1'b0;
        end else begin
            take_q  <= take_any;
            stack_q <= stack_d;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            index_q  <= '0;
            iprio_q  <= npic_pkg::LVL3;
            vector_q <= 16'h0000;
        end else if (take_any) begin
            index_q  <= idx_d;
            iprio_q  <= cc_d;
            vector_q <= vec_d;
        end
    end

    assign prio_level_hi = cc_q[1];
    assign prio_level_lo = cc_q[0];
    assign sleep_wait    = (sleep_q == npic_pkg::NPIC_WAIT);
    assign sleep_halt    = in_halt;
    assign irq_take      = take_q;
    assign irq_stack     = stack_q;
    assign irq_index     = index_q;
    assign irq_prio      = iprio_q;
    assign irq_vector    = vector_q;

endmodule : npic_ctrl

// ==== sim/npic_ctrl_monitor.sv ====
// Checker for the interrupt controller's entry and priority pair behaviour.
// Assumes it is bound to npic_ctrl and sees only its ports.
`timescale 1ns/1ps

module npic_ctrl_monitor (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        service_return_op,
    input wire logic        cc_pop,
    input wire logic [7:0]  cc_restore,
    input wire logic        unmask_all_op,
    input wire logic        mask_all_op,
    input wire logic        prio_level_hi,
    input wire logic        prio_level_lo,
    input wire logic        irq_take,
    input wire logic        irq_stack,
    input wire logic [3:0]  irq_index,
    input wire logic [1:0]  irq_prio,
    input wire logic [15:0] irq_vector
);
    ////////////////////////////////////////////////////////////////
    wire [1:0] pair     = {prio_level_hi, prio_level_lo};
    wire [1:0] ret_pair = {cc_restore[5], cc_restore[3]};

    // Ordinal of a pair, lowest level first
    function automatic logic [1:0] rk(input logic [1:0] l);
        return (l == 2'h2) ? 2'h0 : (l == 2'h1) ? 2'h1 : (l == 2'h0) ? 2'h2 : 2'h3;
    endfunction : rk

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence s_ret;
        service_return_op ##1 !irq_take;
    endsequence
    sequence s_mask;
        mask_all_op && !service_return_op && !cc_pop;
    endsequence
    sequence s_unmask;
        unmask_all_op && !mask_all_op && !service_return_op && !cc_pop;
    endsequence

    reset_entry_a: assert property (
        irq_take && irq_index == 4'hF |-> !irq_stack && irq_vector == npic_pkg::VEC_RESET)
        else $error("reset entry wrong");
    trap_entry_a: assert property (
        irq_take && irq_index == 4'hE |->
        irq_stack && irq_vector == npic_pkg::VEC_TRAP && irq_prio == npic_pkg::LVL3)
        else $error("trap entry wrong");
    vector_map_a: assert property (
        irq_take && irq_index < 4'hE |->
        irq_stack && irq_vector == npic_pkg::VEC_BASE - {11'h000, irq_index, 1'b0})
        else $error("vector address wrong");
    entry_prio_a: assert property (
        irq_take |-> pair == irq_prio)
        else $error("entry level not loaded");
    strict_level_a: assert property (
        irq_take && irq_index < 4'hE |-> rk(irq_prio) > rk($past(pair)))
        else $error("level not above current");
    return_level_a: assert property (
        s_ret |-> pair == $past(ret_pair))
        else $error("return level not restored");
    unmask_level_a: assert property (
        s_unmask |=> irq_take || pair == npic_pkg::LVL0)
        else $error("unmask level wrong");
    mask_level_a: assert property (
        s_mask |=> irq_take || pair == npic_pkg::LVL3)
        else $error("mask level wrong");
endmodule : npic_ctrl_monitor

bind npic_ctrl npic_ctrl_monitor u_mon (.clk(clk), .resetn(resetn),
    .service_return_op(service_return_op), .cc_pop(cc_pop), .cc_restore(cc_restore),
    .unmask_all_op(unmask_all_op), .mask_all_op(mask_all_op),
    .prio_level_hi(prio_level_hi), .prio_level_lo(prio_level_lo), .irq_take(irq_take),
    .irq_stack(irq_stack), .irq_index(irq_index), .irq_prio(irq_prio),
    .irq_vector(irq_vector));

// ==== sim/npic_cpu_model.sv ====
// Behavioural CPU sequencer: boundaries, stacking of the pair, returns.
// Assumes one return request per stacked entry.
`timescale 1ns/1ps

module npic_cpu_model (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       irq_take,
    input  wire logic       irq_stack,
    input  wire logic       prio_hi,
    input  wire logic       prio_lo,
    input  wire logic       ret_req,
    input  wire logic       slow,
    output logic            instr_boundary,
    output logic            service_return_op,
    output logic            cc_pop,
    output logic [7:0]      cc_restore
);
    ////////////////////////////////////////////////////////////////
    logic [1:0] prev_q;
    logic [1:0] gap_q;
    logic [2:0] sp_q;
    logic [1:0] stk_q [0:7];
    wire  [1:0] top = stk_q[sp_q - 3'h1];

    assign cc_pop = 1'b0;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prev_q            <= 2'h3;
            gap_q             <= 2'h0;
            sp_q              <= 3'h0;
            instr_boundary    <= 1'b0;
            service_return_op <= 1'b0;
            cc_restore        <= 8'h00;
        end else begin
            prev_q            <= {prio_hi, prio_lo};
            gap_q             <= gap_q + 2'h1;
            instr_boundary    <= !slow || gap_q == 2'h3;
            service_return_op <= ret_req;
            cc_restore        <= ret_req ? {2'h0, top[1], 1'b0, top[0], 3'h0} : ~cc_restore;
            if (irq_take && irq_stack) begin
                stk_q[sp_q] <= prev_q;
                sp_q        <= sp_q + 3'h1;
            end else if (ret_req) begin
                sp_q        <= sp_q - 3'h1;
            end
        end
    end
endmodule : npic_cpu_model

// ==== sim/tb.sv ====
// Self-checking bench for the interrupt controller over APB and core pins.
// Assumes the CPU model answers takes and returns.
`timescale 1ns/1ps

module tb;
    ////////////////////////////////////////////////////////////////
    logic        clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, slow = 1'b0, ib, sro, ccp, ph, pl, slw, slh, tk, stk;
    logic [15:0] ext_pin = 16'h0, ext_pin_en = 16'h0, vec;
    logic [9:0]  pflag = 10'h0, pen = 10'h0, pclr = 10'h0;
    logic [5:0]  ops = 6'h0;
    logic [7:0]  ccr;
    logic [3:0]  idx;
    logic [1:0]  ipr;
    int          miscompares = 0;
    int          checks_done = 0;

    always #2.5 clk = ~clk;

    npic_ctrl DUT (.clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_pin(ext_pin), .ext_pin_en(ext_pin_en), .periph_flag(pflag), .periph_en(pen),
        .periph_clear(pclr), .instr_boundary(ib), .trap_op(ops[0]), .unmask_all_op(ops[1]),
        .mask_all_op(ops[2]), .halt_op(ops[3]), .sleep_until_event_op(ops[4]),
        .service_return_op(sro), .cc_pop(ccp), .cc_restore(ccr), .prio_level_hi(ph),
        .prio_level_lo(pl), .sleep_wait(slw), .sleep_halt(slh), .irq_take(tk),
        .irq_stack(stk), .irq_index(idx), .irq_prio(ipr), .irq_vector(vec));
    npic_cpu_model u_cpu (.clk(clk), .resetn(resetn), .irq_take(tk), .irq_stack(stk),
        .prio_hi(ph), .prio_lo(pl), .ret_req(ops[5]), .slow(slow), .instr_boundary(ib),
        .service_return_op(sro), .cc_pop(ccp), .cc_restore(ccr));

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask : rdc

    task op(input int k);
        @(posedge clk);
        ops[k] <= 1'b1;
        @(posedge clk);
        ops[k] <= 1'b0;
    endtask : op

    task take(input logic [3:0] i, input logic [15:0] v, input logic [1:0] p);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (tk !== 1'b1 && n < 60);
        chk("take", 1, tk);
        chk("index", i, idx);
        chk("vector", v, vec);
        chk("prio", p, ipr);
    endtask : take

    task results;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results

    initial begin
        #60000;
        miscompares++;
        results();
    end

    initial begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        take(4'hF, 16'hFFFE, 2'h3);
        rdc("prio0", 8'h00, 32'hFF);
        rdc("prio3", 8'h0C, 32'hFF);
        rdc("haltcap", 8'h14, 32'hF);
        apb(1'b0, 8'h18, 32'h0);
        chk("slverr", 1, err);
        apb(1'b1, 8'h00, 32'hCF);
        apb(1'b1, 8'h00, 32'h64);
        rdc("prio0", 8'h00, 32'h44);
        $display("test registers done");
        @(posedge clk);
        ext_pin_en <= 16'h0014;
        @(posedge clk);
        ext_pin <= 16'h0014;
        rdc("pending", 8'h10, 32'h3);
        op(1);
        take(4'h0, 16'hFFFA, 2'h0);
        rdc("pending", 8'h10, 32'h2);
        op(5);
        take(4'h1, 16'hFFF8, 2'h1);
        op(5);
        repeat (2) @(negedge clk);
        chk("pair", 2'h2, {ph, pl});
        $display("test arbitration done");
        op(2);
        op(0);
        take(4'hE, 16'hFFFC, 2'h3);
        op(5);
        $display("test trap done");
        pen <= 10'h001;
        pflag <= 10'h003;
        rdc("pending", 8'h10, 32'h10);
        pflag <= 10'h000;
        pclr <= 10'h001;
        @(posedge clk);
        pclr <= 10'h000;
        rdc("pending", 8'h10, 32'h0);
        $display("test peripheral done");
        slow <= 1'b1;
        pflag <= 10'h001;
        ext_pin_en <= 16'h0100;
        ext_pin <= 16'h0100;
        op(3);
        @(negedge clk);
        chk("halt", 1, slh);
        take(4'h2, 16'hFFF6, 2'h0);
        take(4'h4, 16'hFFF2, 2'h3);
        pflag <= 10'h000;
        pclr <= 10'h001;
        @(posedge clk);
        pclr <= 10'h000;
        op(5);
        op(5);
        $display("test halt done");
        op(4);
        @(negedge clk);
        chk("wait", 1, slw);
        @(posedge clk);
        ext_pin <= 16'h0000;
        @(posedge clk);
        ext_pin <= 16'h0100;
        take(4'h2, 16'hFFF6, 2'h0);
        chk("wake", 0, slw);
        op(5);
        $display("test wait done");
        results();
    end
endmodule : tb
